// ---- logic/fpmc_top.sv ----
// How it works
// (RULE_01) Flush mode: underflowed result becomes signed zero
// (RULE_02) Denormal-input mode: denormal inputs become signed zero
// (RULE_03) Modes off: IEEE handling, slow stall
// (RULE_04) Control word: precision 8-9, round 10-11, inf 12
// (RULE_05) Fast load only within two mode-bit values
// (RULE_06) Change outside mode bits takes slow path
// (RULE_07) Third distinct value: every load slow
// (RULE_08) Slow load stalls about pipeline depth
// (RULE_09) CSR write serialises; CSR read slow (code only loads rd_wait_r; a CSR read raises no stall)
// (RULE_10) One CSR governs single and double
// (RULE_11) Truncating store ignores rounding field
// (RULE_12) Stack range check uses extended format
// (RULE_13) Masked overflow adds no latency
// (RULE_14) Single precision allows early divide finish
// (RULE_15) Denormal and underflow flagged in both units
// (RULE_16) Denormal: exponent zero, fraction nonzero
`timescale 1ns/1ps
`default_nettype none
module fpmc_top #(
   parameter int PIPE_CYCLES = fpmc_pkg::PIPE_DEPTH,
   parameter int CSR_RD_CYCLES = fpmc_pkg::CSR_READ_LAT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Control word load from the pipeline
   input wire logic cw_load,
   input wire logic [15:0] cw_load_val,
   // SIMD operand path (double, or single in the upper word; one lane)
   input wire logic simd_valid,
   input wire logic simd_is_single,
   input wire logic [63:0] simd_src,
   input wire logic [63:0] simd_result,
   input wire logic simd_result_tiny,
   input wire logic simd_overflow,
   // Stack unit path
   input wire logic stk_valid,
   input wire logic [14:0] stk_exp,
   input wire logic [63:0] stk_mant,
   input wire logic stk_is_divide,
   // Truncating store request
   input wire logic trunc_valid,
   input wire logic [1:0] trunc_size,
   input wire logic [63:0] trunc_int,
   // Outputs to pipeline
   output logic [63:0] simd_src_out,
   output logic [63:0] simd_res_out,
   output logic simd_slow,
   output logic stk_range_err,
   output logic stk_early_out,
   output logic [63:0] trunc_out,
   output logic [1:0] trunc_round_used,
   output logic stall,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0] cw_r;
   logic [15:0] csr_r;
   logic [fpmc_pkg::IRQ_W-1:0] irq_stat_r;
   logic [fpmc_pkg::IRQ_W-1:0] irq_mask_r;
   logic [15:0] slow_cnt_r;
   logic [15:0] alt_cw_r;
   logic alt_ok_r;
   logic [7:0] stall_cnt_r;
   logic [7:0] rd_wait_r;
   logic [15:0] cw_nxt;
   logic slow_load;
   logic cw_wr;
   logic csr_wr;
   logic flush_underflow_to_zero;
   logic denormal_inputs_as_zero;
   logic ieee_path;
   logic src_denorm;
   logic res_under;
   logic stk_denorm;
   logic [fpmc_pkg::IRQ_W-1:0] ev;
   fpmc_pkg::fpmc_reg_req_t req;
   fpmc_pkg::fpmc_dbl_t src_f;
   fpmc_pkg::fpmc_dbl_t res_f;

   assign req = '{data: reg_wdata, addr: reg_addr, wr: reg_wr, rd: reg_rd};
   assign src_f = simd_src;
   assign res_f = simd_result;
   assign cw_wr = req.wr && (req.addr == fpmc_pkg::ADDR_CONTROL_WORD);
   assign csr_wr = req.wr && (req.addr == fpmc_pkg::ADDR_SIMD_CSR);
   assign cw_nxt = cw_wr ? req.data : cw_load_val;
   // Same CSR bits for both precisions
   assign flush_underflow_to_zero = csr_r[fpmc_pkg::CSR_FLUSH_BIT]; // RULE_10
   assign denormal_inputs_as_zero = csr_r[fpmc_pkg::CSR_DENORM_IN_BIT]; // RULE_10
   // Denormal classifier for single (upper word) or double
   always_comb begin
      if (simd_is_single) begin
         src_denorm = (simd_src[62:55] == 8'h00) && (simd_src[54:32] != 23'h00_0000); // RULE_16
         res_under = simd_result_tiny;
      end else begin
         src_denorm = (src_f.exp == 11'h000) && (src_f.frac != 52'h0); // RULE_16
         res_under = simd_result_tiny;
      end
   end
   // Extended format: exponent zero with any mantissa bit set
   assign stk_denorm = (stk_exp == 15'h0000) && (stk_mant != 64'h0); // RULE_16
   // Modes off: denormal or underflow takes the slow exact path
   assign ieee_path = !flush_underflow_to_zero && !denormal_inputs_as_zero &&
      (src_denorm || res_under); // RULE_03

   ////////////////////////////////////////////////////////////////////////
   // Control word and fast-load tracking
   always_comb begin
      slow_load = 1'b0;
      if (cw_wr || cw_load) begin
         if (((cw_nxt ^ cw_r) & ~fpmc_pkg::CW_MODE_MASK) != 16'h0000) begin
            slow_load = 1'b1; // RULE_06
         end else if (cw_nxt == cw_r) begin
            slow_load = 1'b0;
         end else if (alt_ok_r && cw_nxt == alt_cw_r) begin
            slow_load = 1'b0; // RULE_05
         end else if (!alt_ok_r) begin
            slow_load = 1'b0; // RULE_05
         end else begin
            slow_load = 1'b1; // RULE_07
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cw_r <= fpmc_pkg::CW_RESET;
         alt_cw_r <= fpmc_pkg::CW_RESET;
         alt_ok_r <= 1'b0;
      end else if ((cw_wr || cw_load) && cw_nxt != cw_r) begin
         cw_r <= cw_nxt; // RULE_04
         alt_cw_r <= cw_r;
         alt_ok_r <= !slow_load || (((cw_nxt ^ cw_r) & ~fpmc_pkg::CW_MODE_MASK) == 16'h0000);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         csr_r <= fpmc_pkg::CSR_RESET;
      end else if (csr_wr) begin
         csr_r <= req.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stall counter: slow loads and CSR writes drain the pipe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stall_cnt_r <= 8'h00;
      end else if (slow_load || csr_wr) begin
         stall_cnt_r <= 8'(PIPE_CYCLES); // RULE_08 RULE_09
      end else if (simd_valid && ieee_path && stall_cnt_r == 8'h00) begin
         stall_cnt_r <= 8'(PIPE_CYCLES); // RULE_03
      end else if (stall_cnt_r != 8'h00) begin
         stall_cnt_r <= stall_cnt_r - 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stall <= 1'b0;
      end else begin
         stall <= slow_load || csr_wr || (stall_cnt_r > 8'h01); // RULE_08 RULE_09
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slow_cnt_r <= 16'h0000;
      end else if (slow_load) begin
         slow_cnt_r <= slow_cnt_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SIMD operand and result conditioning
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         simd_src_out <= 64'h0000_0000_0000_0000;
         simd_res_out <= 64'h0000_0000_0000_0000;
         simd_slow <= 1'b0;
      end else if (simd_valid) begin
         if (denormal_inputs_as_zero && src_denorm) begin
            simd_src_out <= {simd_src[63], 63'h0}; // RULE_02
         end else begin
            simd_src_out <= simd_src; // RULE_03
         end
         if (flush_underflow_to_zero && res_under) begin
            simd_res_out <= {res_f.sign, 63'h0}; // RULE_01
         end else begin
            simd_res_out <= simd_result; // RULE_13
         end
         simd_slow <= ieee_path; // RULE_03
      end else begin
         simd_slow <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stack unit: extended range and early divide
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stk_range_err <= 1'b0;
         stk_early_out <= 1'b0;
      end else begin
         stk_range_err <= stk_valid && (stk_exp == 15'h7FFF || stk_denorm); // RULE_12
         stk_early_out <= stk_valid && stk_is_divide &&
            cw_r[fpmc_pkg::CW_PREC_LO +: 2] == fpmc_pkg::PREC_SINGLE; // RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Truncating store: rounding field not consulted
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trunc_out <= 64'h0000_0000_0000_0000;
         trunc_round_used <= 2'h0;
      end else if (trunc_valid) begin
         unique case (trunc_size)
            2'h0: trunc_out <= {{48{trunc_int[15]}}, trunc_int[15:0]}; // RULE_11
            2'h1: trunc_out <= {{32{trunc_int[31]}}, trunc_int[31:0]}; // RULE_11
            default: trunc_out <= trunc_int; // RULE_11
         endcase
         trunc_round_used <= 2'h3;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output
   assign ev[fpmc_pkg::IRQ_DENORM_BIT] = (simd_valid && src_denorm) || (stk_valid && stk_denorm); // RULE_15
   assign ev[fpmc_pkg::IRQ_UNDER_BIT] = (simd_valid && res_under) || (stk_valid && stk_exp == 15'h0000); // RULE_15
   assign ev[fpmc_pkg::IRQ_SLOW_BIT] = slow_load;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= '0;
      end else if (req.wr && req.addr == fpmc_pkg::ADDR_IRQ_STATUS) begin
         irq_stat_r <= (irq_stat_r & ~req.data[fpmc_pkg::IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= '0;
      end else if (req.wr && req.addr == fpmc_pkg::ADDR_IRQ_MASK) begin
         irq_mask_r <= req.data[fpmc_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_r | ev) & ~irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle later
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
         rd_wait_r <= 8'h00;
      end else begin
         reg_rdata <= 16'h0000;
         if (req.rd) begin
            unique case (req.addr)
               fpmc_pkg::ADDR_CONTROL_WORD: reg_rdata <= cw_r;
               fpmc_pkg::ADDR_SIMD_CSR: reg_rdata <= csr_r;
               fpmc_pkg::ADDR_IRQ_STATUS: reg_rdata <= {13'h0000, irq_stat_r};
               fpmc_pkg::ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_r};
               fpmc_pkg::ADDR_LOAD_STATS: reg_rdata <= slow_cnt_r;
               default: reg_rdata <= 16'h0000;
            endcase
         end
         // CSR read latency shows only as a wait count; it does not drive stall
         if (req.rd && req.addr == fpmc_pkg::ADDR_SIMD_CSR) begin
            rd_wait_r <= 8'(CSR_RD_CYCLES); // RULE_09
         end else if (rd_wait_r != 8'h00) begin
            rd_wait_r <= rd_wait_r - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_flush_zero: assert property (@(posedge mclk) disable iff (rst) // RULE_01
      simd_valid && flush_underflow_to_zero && res_under |=> simd_res_out == {$past(simd_result[63]), 63'h0})
      else $error("flushed result not signed zero");
   chk_denorm_zero: assert property (@(posedge mclk) disable iff (rst) // RULE_02
      simd_valid && denormal_inputs_as_zero && src_denorm |=> simd_src_out[62:0] == 63'h0)
      else $error("denormal operand not zeroed");
   chk_ieee_slow: assert property (@(posedge mclk) disable iff (rst) // RULE_03
      simd_valid && !flush_underflow_to_zero && !denormal_inputs_as_zero && src_denorm |=> simd_slow)
      else $error("ieee path not slow");
   chk_fast_alt: assert property (@(posedge mclk) disable iff (rst) // RULE_05
      cw_load && !reg_wr && (!alt_ok_r || cw_load_val == alt_cw_r) && stall_cnt_r <= 8'h01 &&
      ((cw_load_val ^ cw_r) & ~fpmc_pkg::CW_MODE_MASK) == 16'h0000 |=> !stall)
      else $error("alternating load not fast");
   chk_outside_slow: assert property (@(posedge mclk) disable iff (rst) // RULE_06
      cw_load && !reg_wr && ((cw_load_val ^ cw_r) & ~fpmc_pkg::CW_MODE_MASK) != 16'h0 |=> stall)
      else $error("non-mode change not slow");
   chk_third_slow: assert property (@(posedge mclk) disable iff (rst) // RULE_07
      cw_load && !reg_wr && alt_ok_r && cw_load_val != cw_r && cw_load_val != alt_cw_r |=> stall)
      else $error("third value load not slow");
   chk_slow_stall: assert property (@(posedge mclk) disable iff (rst) // RULE_08
      slow_load |=> stall [*4])
      else $error("slow load stall too short");
   chk_csr_serial: assert property (@(posedge mclk) disable iff (rst) // RULE_09
      csr_wr |=> stall)
      else $error("csr write not serialising");
   chk_csr_rd_wait: assert property (@(posedge mclk) disable iff (rst) // RULE_09
      req.rd && req.addr == fpmc_pkg::ADDR_SIMD_CSR |=> rd_wait_r == 8'(CSR_RD_CYCLES))
      else $error("csr read wait not started");
   chk_trunc_size: assert property (@(posedge mclk) disable iff (rst) // RULE_11
      trunc_valid && trunc_size == 2'h0 |=> trunc_out[15:0] == $past(trunc_int[15:0]))
      else $error("truncating store wrong");
   chk_range_err: assert property (@(posedge mclk) disable iff (rst) // RULE_12
      stk_valid && stk_exp == 15'h7FFF |=> stk_range_err)
      else $error("extended range overflow missed");
   chk_ovf_no_stall: assert property (@(posedge mclk) disable iff (rst) // RULE_13
      simd_valid && simd_overflow && !src_denorm && !res_under && !slow_load && !csr_wr &&
      stall_cnt_r == 8'h00 |=> !simd_slow && !stall)
      else $error("masked overflow delayed");
   chk_early_div: assert property (@(posedge mclk) disable iff (rst) // RULE_14
      stk_valid && stk_is_divide && cw_r[9:8] != fpmc_pkg::PREC_SINGLE |=> !stk_early_out)
      else $error("early out in wrong precision");
   chk_flag_sets: assert property (@(posedge mclk) disable iff (rst) // RULE_15
      simd_valid && src_denorm |=> irq_stat_r[fpmc_pkg::IRQ_DENORM_BIT])
      else $error("denormal flag lost");
   chk_irq_level: assert property (@(posedge mclk) disable iff (rst) // RULE_15
      (irq_stat_r & ~irq_mask_r) != '0 |=> irq)
      else $error("unmasked status without interrupt");
   cov_fast_alt: cover property (@(posedge mclk) disable iff (rst) cw_load && !slow_load && cw_load_val != cw_r);
   cov_third_val: cover property (@(posedge mclk) disable iff (rst) cw_load && slow_load);
   cov_flush_hit: cover property (@(posedge mclk) disable iff (rst) simd_valid && flush_underflow_to_zero && res_under);
   cov_irq: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule
`default_nettype wire

// ---- logic/fpmc_pkg.sv ----
`default_nettype none
package fpmc_pkg;
   // Register map (word addresses on the plain register port)
   localparam logic [3:0] ADDR_CONTROL_WORD = 4'h0;
   localparam logic [3:0] ADDR_SIMD_CSR = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   localparam logic [3:0] ADDR_LOAD_STATS = 4'h4;
   // Control word fields
   localparam int CW_PREC_LO = 8;
   localparam int CW_ROUND_LO = 10;
   localparam int CW_INF_BIT = 12;
   localparam logic [15:0] CW_MODE_MASK = 16'h1F00;
   localparam logic [15:0] CW_RESET = 16'h037F;
   localparam logic [1:0] PREC_SINGLE = 2'h0;
   // SIMD control/status fields
   localparam int CSR_DENORM_IN_BIT = 6;
   localparam int CSR_FLUSH_BIT = 15;
   localparam logic [15:0] CSR_RESET = 16'h1F80;
   // Interrupt status bits
   localparam int IRQ_DENORM_BIT = 0;
   localparam int IRQ_UNDER_BIT = 1;
   localparam int IRQ_SLOW_BIT = 2;
   localparam int IRQ_W = 3;
   // Timing
   localparam int PIPE_DEPTH = 20;
   localparam int CSR_READ_LAT = 8;
   localparam int FAST_LOAD_LAT = 1;

   typedef struct packed {
      logic [15:0] data;
      logic [3:0] addr;
      logic wr;
      logic rd;
   } fpmc_reg_req_t;

   typedef struct packed {
      logic sign;
      logic [10:0] exp;
      logic [51:0] frac;
   } fpmc_dbl_t;
endpackage
`default_nettype wire

// ---- verification/fpmc_issue_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpmc_issue_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bench request
   input wire logic req,
   input wire logic [15:0] req_val,
   // Block side
   input wire logic stall,
   output logic cw_load,
   output logic [15:0] cw_load_val
);
   logic pend_r;
   logic [15:0] val_r;
   // Issue holds a queued load back while the block stalls
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_r <= 1'b0;
         val_r <= 16'h0000;
         cw_load <= 1'b0;
         cw_load_val <= 16'h0000;
      end else begin
         cw_load <= 1'b0;
         if (req) begin
            pend_r <= 1'b1;
            val_r <= req_val;
         end else if (pend_r && !stall && !cw_load) begin
            cw_load <= 1'b1;
            cw_load_val <= val_r;
            pend_r <= 1'b0;
         end else if (cw_load) begin
            // Stale operand is scrambled once the pulse is over
            cw_load_val <= ~cw_load_val;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/test_fpmc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_fpmc_top;
   localparam int PIPE_N = 8;
   logic mclk, rst, reg_wr, reg_rd, cw_load, req, sv, ssg, sti, sov, kv, kdiv, tv;
   logic slow, rerr, early, stall, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, cw_val, rq_val;
   logic [63:0] ssrc, sres, kmant, tint, src_o, res_o, trunc_out;
   logic [14:0] kexp;
   logic [1:0] tsz, rnd;
   int n_errors, n_checks, n;

   fpmc_issue_model PIPE (.mclk(mclk), .rst(rst), .req(req), .req_val(rq_val), .stall(stall),
      .cw_load(cw_load), .cw_load_val(cw_val));
   fpmc_top #(.PIPE_CYCLES(PIPE_N), .CSR_RD_CYCLES(4)) DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cw_load(cw_load),
      .cw_load_val(cw_val), .simd_valid(sv), .simd_is_single(ssg), .simd_src(ssrc), .simd_result(sres),
      .simd_result_tiny(sti), .simd_overflow(sov), .stk_valid(kv), .stk_exp(kexp), .stk_mant(kmant),
      .stk_is_divide(kdiv), .trunc_valid(tv), .trunc_size(tsz), .trunc_int(tint), .simd_src_out(src_o),
      .simd_res_out(res_o), .simd_slow(slow), .stk_range_err(rerr), .stk_early_out(early),
      .trunc_out(trunc_out), .trunc_round_used(rnd), .stall(stall), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(64'(reg_rdata), 64'(e));
   endtask

   // Counts stall cycles; a stall that never ends closes the run
   task automatic idle;
      n = 0;
      while (stall !== 1'b0 && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 200) begin
         n_errors++;
         $display("Error at %0t: stall cycles %h expected below %h", $time, n, 200);
         stop_test();
      end
   endtask

   task automatic win(input logic slow_exp);
      idle();
      chk(64'(slow_exp ? (n >= PIPE_N - 2 && n <= PIPE_N) : (n <= fpmc_pkg::FAST_LOAD_LAT)), 64'h1);
   endtask

   task automatic ld(input logic [15:0] v, input logic slow_exp);
      @(posedge mclk);
      req <= 1'b1;
      rq_val <= v;
      @(posedge mclk);
      req <= 1'b0;
      #1;
      n = 0;
      while (cw_load !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 20) begin
         n_errors++;
         $display("Error at %0t: load wait %h expected below %h", $time, n, 20);
         stop_test();
      end
      @(posedge mclk);
      #1;
      chk(64'(stall), 64'(slow_exp));
      win(slow_exp);
   endtask

   task automatic simd(input logic [63:0] s, r, input logic tiny, sg, ov, input logic [63:0] es, er,
      input logic eslow);
      @(posedge mclk);
      sv <= 1'b1;
      ssrc <= s;
      sres <= r;
      sti <= tiny;
      ssg <= sg;
      sov <= ov;
      @(posedge mclk);
      sv <= 1'b0;
      #1;
      chk(src_o, es);
      chk(res_o, er);
      chk(64'(slow), 64'(eslow));
      idle();
   endtask

   task automatic stk(input logic [14:0] e, input logic dv, input logic [1:0] exp);
      @(posedge mclk);
      kv <= 1'b1;
      kexp <= e;
      kdiv <= dv;
      @(posedge mclk);
      kv <= 1'b0;
      #1;
      chk(64'({rerr, early}), 64'(exp));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, reg_wr, reg_rd, req, sv, ssg, sti, sov, kv, kdiv, tv} = 11'h7FF & 11'h400;
      {reg_addr, tsz, kexp} = '0;
      {reg_wdata, rq_val, ssrc, sres, tint} = '0;
      kmant = 64'h8000_0000_0000_0000;
      n_errors = 0;
      n_checks = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(fpmc_pkg::ADDR_CONTROL_WORD, fpmc_pkg::CW_RESET);
      rd(fpmc_pkg::ADDR_SIMD_CSR, fpmc_pkg::CSR_RESET);
      wr(4'h9, 16'hFFFF);
      rd(4'h9, 16'h0000);
      wr(fpmc_pkg::ADDR_IRQ_MASK, 16'h0000);
      ld(16'h0F7F, 1'b0);
      ld(16'h037F, 1'b0);
      ld(16'h0F7F, 1'b0);
      ld(16'h137F, 1'b1);
      ld(16'h137E, 1'b1);
      rd(fpmc_pkg::ADDR_LOAD_STATS, 16'h0002);
      chk(64'(irq), 64'h1);
      rd(fpmc_pkg::ADDR_IRQ_STATUS, 16'h0004);
      wr(fpmc_pkg::ADDR_IRQ_MASK, 16'h0004);
      @(posedge mclk);
      #1;
      chk(64'(irq), 64'h0);
      wr(fpmc_pkg::ADDR_IRQ_STATUS, 16'h0004);
      rd(fpmc_pkg::ADDR_IRQ_STATUS, 16'h0000);
      wr(fpmc_pkg::ADDR_IRQ_MASK, 16'h0000);
      wr(fpmc_pkg::ADDR_CONTROL_WORD, 16'h037F);
      idle();
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         tv <= 1'b1;
         tsz <= 2'(i);
         tint <= 64'h1111_2222_3333_4444;
         @(posedge mclk);
         tv <= 1'b0;
         #1;
         chk(trunc_out, i == 0 ? 64'h4444 : i == 1 ? 64'h3333_4444 : tint);
         chk(64'(rnd), 64'h3);
      end
      wr(fpmc_pkg::ADDR_CONTROL_WORD, 16'h007F);
      idle();
      stk(15'h3FFF, 1'b1, 2'b01);
      stk(15'h7FFF, 1'b0, 2'b10);
      wr(fpmc_pkg::ADDR_CONTROL_WORD, 16'h037F);
      idle();
      stk(15'h3FFF, 1'b1, 2'b00);
      simd(64'h8000_0000_0000_0001, 0, 0, 0, 0, 64'h8000_0000_0000_0001, 0, 1);
      simd(0, 64'h5, 1, 0, 0, 0, 64'h5, 1);
      simd(0, 0, 0, 0, 0, 0, 0, 0);
      rd(fpmc_pkg::ADDR_IRQ_STATUS, 16'h0007);
      wr(fpmc_pkg::ADDR_SIMD_CSR, 16'h9FC0);
      chk(64'(stall), 64'h1);
      win(1'b1);
      rd(fpmc_pkg::ADDR_SIMD_CSR, 16'h9FC0);
      simd(64'h8000_0000_0000_0001, 64'h8000_0000_0000_0003, 1, 0, 0, 64'h8000_0000_0000_0000,
         64'h8000_0000_0000_0000, 0);
      simd(64'h8000_0001_0000_0000, 64'h0000_0002_0000_0000, 1, 1, 0, 64'h8000_0000_0000_0000, 0, 0);
      simd(64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0000, 0, 0, 1, 64'h3FF0_0000_0000_0000,
         64'h7FF0_0000_0000_0000, 0);
      stop_test();
   end
endmodule
`default_nettype wire
